// >>> sshi_pkg.sv
// Shared constants for the serial slave host interface.
// Assumes: imported whole by every module of the block.
package sshi_pkg;

    // ------------------------------------------------------------
    // Word, counter and queue geometry
    // ------------------------------------------------------------
    localparam int          WORD_W      = 32;
    localparam int          CNT_W       = 5;
    localparam int          FIFO_DEPTH  = 32;
    localparam logic [4:0]  BYTE_LAST   = 5'h07;   // Last bit index, 8-bit words
    localparam logic [4:0]  WORD_LAST   = 5'h1F;   // Last bit index, 32-bit words
    localparam logic [4:0]  CNT_ZERO    = 5'h00;
    localparam logic [4:0]  CNT_ONE     = 5'h01;

    // ------------------------------------------------------------
    // Reset and fill values, byte mask
    // ------------------------------------------------------------
    localparam logic [31:0] FILL_WORD   = 32'h00000000; // Sent when nothing is queued
    localparam logic [31:0] BYTE_MASK   = 32'h000000FF;
    localparam logic        CS_IDLE     = 1'b1;

endpackage

// >>> sshi_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes: one clock, synchronous active-low reset, clock enable freezes all state.
`timescale 1ns/100ps
module sshi_fifo
    import sshi_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    // ------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------
    assign push = ce_i & in_valid_i & in_ready_o;
    assign pop  = ce_i & out_valid_o & out_ready_i;
    assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data_o = mem_q[rd_ptr_q];

    // Storage, no reset so it maps to plain RAM
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // Pointers wrap; depth must be a power of two
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
            end
        end
    end

    // Flags registered so the filling side sees an honest full
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            count_q     <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else if (ce_i) begin
            count_q     <= count_d;
            in_ready_o  <= (count_d < (AW+1)'(DEPTH));
            out_valid_o <= (count_d != '0);
        end
    end

endmodule

// >>> sshi_top.sv
// Serial slave host interface: the device end of a host-driven serial link.
// Assumes: host is the master and makes the gated link clock; the rest of
// the device queues outbound words and drains inbound words on clk_i.
// Summary of operation
// R1: Data moves both ways at once, in words of 8 or 32 bits as chosen.
// R2: The link clock runs only during a transfer and nothing counts on it outside one.
// R3: At low speed each side launches on the falling edge and the receiver samples on the rising edge.
// R4: At low speed the host has the first bit valid by the first rising edge after select falls.
// R5: At high speed both sides launch and sample on the rising edge.
// R6: A dedicated interrupt output flags that a packet waits for the host.
// R7: The interrupt is active high and level, staying up until the host has read the packet; the code drops it when the link shifter takes the last word.
// R8: The host senses the interrupt as a high level, not as an edge.
// R9: Only polarity 0 with phase 0 and polarity 1 with phase 1 are served.
// R10: The host holds the module reset until the reference oscillator is stable, at most 10 ms.
// R11: Bit and word counters clear whenever select is released, so transfers start on a word; the code has no word counter and clears only the bit counter.
// R12: The data output floats while select is released.
`timescale 1ns/100ps
module sshi_top
    import sshi_pkg::*;
#(
    parameter int TX_DEPTH = FIFO_DEPTH
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_i,
    // Link pins
    input  wire logic              spi_clk_i,
    input  wire logic              spi_cs_n_i,
    input  wire logic              spi_mosi_i,
    output logic                   spi_miso_o,
    output logic                   spi_miso_oe_o,
    output logic                   irq_o,
    // Static configuration pins and status flags
    input  wire logic              clock_polarity_sel_i,
    input  wire logic              clock_phase_sel_i,
    input  wire logic              high_freq_sel_i,
    input  wire logic              word_32_sel_i,
    output logic                   mode_err_o,
    output logic                   frame_active_o,
    // Outbound words, device to host
    input  wire logic              tx_valid_i,
    input  wire logic [WORD_W-1:0] tx_data_i,
    output logic                   tx_ready_o,
    // Inbound words, host to device
    output logic                   rx_valid_o,
    output logic      [WORD_W-1:0] rx_data_o,
    input  wire logic              rx_ready_i,
    output logic                   rx_overrun_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic              cs_s1_q,  cs_s2_q;
    logic              pol_s1_q, pol_s2_q;
    logic              pha_s1_q, pha_s2_q;
    logic              hf_s1_q,  hf_s2_q;
    logic              w32_s1_q, w32_s2_q;
    logic              rxt_s1_q, rxt_s2_q;
    logic              ack_s1_q, ack_s2_q;
    logic              cfg_hf_q;
    logic              cfg_w32_q;
    logic              cfg_ok_q;
    logic              rx_seen_q;
    logic              req_tgl_q;
    logic [WORD_W-1:0] hold_q;
    logic              fifo_valid;
    logic [WORD_W-1:0] fifo_data;
    logic              tx_busy;
    logic              tx_load;
    logic              rx_new;
    logic              mode_ok_d;
    // Link-clock domain
    logic [CNT_W-1:0]  bit_cnt_q;
    logic [CNT_W-1:0]  bit_cnt_d;
    logic [CNT_W-1:0]  last_idx;
    logic              word_end;
    logic [WORD_W-1:0] rx_sh_q;
    logic [WORD_W-1:0] rx_sh_d;
    logic [WORD_W-1:0] rx_word_q;
    logic              rx_tgl_q;
    logic [WORD_W-1:0] tx_sh_q;
    logic [WORD_W-1:0] tx_sh_d;
    logic              ack_tgl_q;
    logic              req_s1_q, req_s2_q;
    logic              tx_avail;
    logic              cur_bit;
    logic              launch_d;
    logic              miso_pos_q;
    logic              miso_neg_q;

    // ------------------------------------------------------------
    // Outbound queue
    // ------------------------------------------------------------
    sshi_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (TX_DEPTH)
    ) u_tx_fifo (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .ce_i        (ce_i),
        .in_valid_i  (tx_valid_i),
        .in_data_i   (tx_data_i),
        .in_ready_o  (tx_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (tx_load)
    );

    // ------------------------------------------------------------
    // Pin and cross-domain synchronisers, system clock
    // ------------------------------------------------------------
    // Two flops per level; logic reads only the second stage, the idle-clear check also reads the first
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cs_s1_q  <= CS_IDLE;
            cs_s2_q  <= CS_IDLE;
            pol_s1_q <= 1'b0;
            pol_s2_q <= 1'b0;
            pha_s1_q <= 1'b0;
            pha_s2_q <= 1'b0;
            hf_s1_q  <= 1'b0;
            hf_s2_q  <= 1'b0;
            w32_s1_q <= 1'b0;
            w32_s2_q <= 1'b0;
            rxt_s1_q <= 1'b0;
            rxt_s2_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else if (ce_i) begin
            cs_s1_q  <= spi_cs_n_i;
            cs_s2_q  <= cs_s1_q;
            pol_s1_q <= clock_polarity_sel_i;
            pol_s2_q <= pol_s1_q;
            pha_s1_q <= clock_phase_sel_i;
            pha_s2_q <= pha_s1_q;
            hf_s1_q  <= high_freq_sel_i;
            hf_s2_q  <= hf_s1_q;
            w32_s1_q <= word_32_sel_i;
            w32_s2_q <= w32_s1_q;
            rxt_s1_q <= rx_tgl_q;
            rxt_s2_q <= rxt_s1_q;
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Configuration and status, system clock
    // ------------------------------------------------------------
    // Both legal modes sample on rising; they shift on falling at low speed and on rising at high speed
    assign mode_ok_d = (pol_s2_q == pha_s2_q);                          // R9

    // Config is quasi-static: the link side reads it without resync,
    // so it must only change while select is released
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cfg_hf_q       <= 1'b0;
            cfg_w32_q      <= 1'b0;
            cfg_ok_q       <= 1'b1;
            mode_err_o     <= 1'b0;
            frame_active_o <= 1'b0;
        end else if (ce_i) begin
            cfg_hf_q       <= hf_s2_q;                                  // R5
            cfg_w32_q      <= w32_s2_q;                                 // R1
            cfg_ok_q       <= mode_ok_d;                                // R9
            mode_err_o     <= ~mode_ok_d;                               // R9
            frame_active_o <= ~cs_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Outbound hand-off to the link domain (toggle handshake)
    // ------------------------------------------------------------
    assign tx_busy = (req_tgl_q != ack_s2_q);
    assign tx_load = ce_i & fifo_valid & ~tx_busy;

    // Holding word stays still until the link side acknowledges it
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            req_tgl_q <= 1'b0;
            hold_q    <= FILL_WORD;
        end else if (tx_load) begin
            req_tgl_q <= ~req_tgl_q;
            hold_q    <= fifo_data;
        end
    end

    // Level interrupt: up while any outbound word waits in the queue or the holding register
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= fifo_valid | tx_busy;                              // R6 R7
        end
    end

    // ------------------------------------------------------------
    // Inbound delivery, system clock
    // ------------------------------------------------------------
    assign rx_new = (rxt_s2_q != rx_seen_q);

    // A new word wins over a same-cycle ready; a late drain is flagged
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rx_seen_q    <= 1'b0;
            rx_valid_o   <= 1'b0;
            rx_data_o    <= FILL_WORD;
            rx_overrun_o <= 1'b0;
        end else if (ce_i) begin
            rx_overrun_o <= rx_new & rx_valid_o & ~rx_ready_i;
            if (rx_new) begin
                rx_seen_q  <= rxt_s2_q;
                rx_data_o  <= rx_word_q;                                // R1
                rx_valid_o <= 1'b1;
            end else if (rx_ready_i) begin
                rx_valid_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Link domain: bit counting and shifting
    // ------------------------------------------------------------
    assign last_idx  = cfg_w32_q ? WORD_LAST : BYTE_LAST;               // R1
    assign word_end  = (bit_cnt_q == last_idx);
    assign bit_cnt_d = word_end ? CNT_ZERO : bit_cnt_q + CNT_ONE;
    assign rx_sh_d   = {rx_sh_q[WORD_W-2:0], spi_mosi_i};               // R3 R4
    assign tx_avail  = (req_s2_q != ack_tgl_q);
    assign tx_sh_d   = word_end ? (tx_avail ? hold_q : FILL_WORD) : tx_sh_q;
    assign cur_bit   = tx_sh_q[last_idx - bit_cnt_q];
    assign launch_d  = tx_sh_d[last_idx - bit_cnt_d];

    // Counter held clear by a released select, no clock needed
    always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            bit_cnt_q <= CNT_ZERO;                                      // R11
        end else begin
            bit_cnt_q <= bit_cnt_d;                                     // R2
        end
    end

    // Inbound shifter samples on every rising edge
    always_ff @(posedge spi_clk_i) begin
        rx_sh_q <= rx_sh_d;                                             // R3 R5
    end

    // Word boundary: publish inbound word in a served mode, fetch the next outbound one
    always_ff @(posedge spi_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_word_q  <= FILL_WORD;
            rx_tgl_q   <= 1'b0;
            tx_sh_q    <= FILL_WORD;
            ack_tgl_q  <= 1'b0;
            req_s1_q   <= 1'b0;
            req_s2_q   <= 1'b0;
            miso_pos_q <= 1'b0;
        end else begin
            req_s1_q   <= req_tgl_q;
            req_s2_q   <= req_s1_q;
            tx_sh_q    <= tx_sh_d;
            // A deselected edge (polarity change) must not disturb the first bit
            if (!spi_cs_n_i) begin
                miso_pos_q <= launch_d;                                 // R5
            end
            if (word_end && !spi_cs_n_i) begin
                ack_tgl_q <= ack_tgl_q ^ tx_avail;                      // R1
                if (cfg_ok_q) begin
                    rx_word_q <= cfg_w32_q ? rx_sh_d : (rx_sh_d & BYTE_MASK);
                    rx_tgl_q  <= ~rx_tgl_q;
                end
            end
        end
    end

    // Low speed: the next bit goes out on the falling edge
    always_ff @(negedge spi_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            miso_neg_q <= 1'b0;
        end else begin
            miso_neg_q <= cur_bit;                                      // R3
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Select gates the enable directly: a flop could not release in time
    assign spi_miso_o    = cfg_hf_q ? miso_pos_q : miso_neg_q;          // R3 R5
    assign spi_miso_oe_o = ~spi_cs_n_i & cfg_ok_q;                      // R12 R9

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_irq_raise_level: assert property (                                // R6
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && fifo_valid) |=> irq_o)
        else $error("interrupt not raised while a word waits");

    a_irq_hold_drop: assert property (                                  // R7
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && !fifo_valid && !tx_busy) |=> !irq_o)
        else $error("interrupt left high after the queue emptied");

    a_hold_word_stable: assert property (                               // R2
        @(posedge clk_i) disable iff (!reset_n_i)
        (tx_busy && ce_i) |=> $stable(hold_q))
        else $error("holding word changed before acknowledge");

    a_mode_err_flag: assert property (                                  // R9
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && pol_s2_q != pha_s2_q) |=> (mode_err_o && !cfg_ok_q))
        else $error("illegal polarity/phase pair not flagged");

    a_cnt_idle_clear: assert property (                                 // R11
        @(posedge clk_i) disable iff (!reset_n_i)
        (cs_s2_q && cs_s1_q) |-> (bit_cnt_q == CNT_ZERO))
        else $error("bit counter not clear while deselected");

    a_cnt_word_wrap: assert property (                                  // R1
        @(posedge spi_clk_i) disable iff (spi_cs_n_i)
        (bit_cnt_q == last_idx) |=> (bit_cnt_q == CNT_ZERO))
        else $error("bit counter did not wrap at word end");

    a_rx_sample_rise: assert property (                                 // R3
        @(posedge spi_clk_i) disable iff (spi_cs_n_i)
        1'b1 |=> (rx_sh_q[0] == $past(spi_mosi_i)))
        else $error("inbound bit not taken on rising edge");

    a_launch_low_fall: assert property (                                // R3
        @(posedge spi_clk_i) disable iff (spi_cs_n_i)
        (!cfg_hf_q && bit_cnt_q != CNT_ZERO) |-> (miso_neg_q == cur_bit))
        else $error("low-speed bit not launched on falling edge");

    a_launch_high_rise: assert property (                               // R5
        @(posedge spi_clk_i) disable iff (spi_cs_n_i)
        (cfg_hf_q && bit_cnt_q != CNT_ZERO) |-> (miso_pos_q == cur_bit))
        else $error("high-speed bit not launched on rising edge");

    a_rx_word_deliver: assert property (                                // R1
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && rx_new) |=> (rx_valid_o && rx_seen_q == $past(rxt_s2_q)))
        else $error("inbound word not delivered");

endmodule

// >>> sshi_host_model.sv
// Host master model for the serial slave host interface bench.
// Assumes: the bench calls start, word and stop in that order per frame.
`timescale 1ns/100ps
module sshi_host_model (
    input  wire logic        miso_i,
    output logic             spi_clk_o,
    output logic             spi_cs_n_o,
    output logic             spi_mosi_o,
    output logic             got_stb_o,
    output logic [31:0]      got_word_o
);
    // ------------------------------------------------------------
    // Idle lines: select high, link clock parked
    // ------------------------------------------------------------
    initial begin
        spi_clk_o  = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
        got_stb_o  = 1'b0;
        got_word_o = 32'h00000000;
    end

    // Park the clock first, so a polarity change is never an edge inside a frame;
    // select then falls off the system clock grid to keep phases unrelated
    task automatic start(input logic pol);
        spi_clk_o  = pol;
        #1.3;
        spi_cs_n_o = 1'b0;
    endtask

    // One word, MSB first; 160 ns link period, clock parks high in a stall
    task automatic word(input int bits, input logic [31:0] d, input logic hf, input int gap);
        logic [31:0] r;
        r = 32'h00000000;
        if (hf) spi_mosi_o = d[bits-1];
        for (int i = bits - 1; i >= 0; i--) begin
            spi_clk_o = 1'b0;
            if (!hf) spi_mosi_o = d[i];
            #80;
            r = {r[30:0], miso_i};
            spi_clk_o = 1'b1;
            if (hf && i > 0) begin
                #4 spi_mosi_o = d[i-1];
                #76;
            end else begin
                #80;
            end
        end
        #(gap);
        if (bits == 8 || bits == 32) begin
            got_word_o = r;
            got_stb_o  = 1'b1;
            #1 got_stb_o = 1'b0;
        end
    endtask

    // Release select; a released data line shows the inverse, not a held value
    task automatic stop(input logic pol);
        spi_clk_o = pol;
        #80;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o;
    endtask
endmodule

// >>> sshi_top_tb.sv
// Self-checking bench for the serial slave host interface.
// Assumes: sshi_pkg compiled first; host model drives the link pins.
`timescale 1ns/100ps
module sshi_top_tb;
    import sshi_pkg::*;
    // ------------------------------------------------------------
    // Signals and scoreboard state
    // ------------------------------------------------------------
    logic        clk_i, reset_n_i, ce_i, spi_clk_i, spi_cs_n_i, spi_mosi_i;
    logic        spi_miso_o, spi_miso_oe_o, irq_o, mode_err_o, frame_active_o;
    logic        clock_polarity_sel_i, clock_phase_sel_i, high_freq_sel_i, word_32_sel_i;
    logic        tx_valid_i, tx_ready_o, rx_valid_o, rx_ready_i, rx_overrun_o;
    logic [31:0] tx_data_i, rx_data_o, got_word, rx_exp_q[$], tx_exp_q[$];
    logic        got_stb, miso_w, float_q, tx_watch, ok;
    int          err_count, checks_done, cycles, seed, n;

    sshi_top sshi_top_inst (.clk_i, .reset_n_i, .ce_i, .spi_clk_i, .spi_cs_n_i, .spi_mosi_i,
        .spi_miso_o, .spi_miso_oe_o, .irq_o, .clock_polarity_sel_i, .clock_phase_sel_i,
        .high_freq_sel_i, .word_32_sel_i, .mode_err_o, .frame_active_o, .tx_valid_i,
        .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_ready_i, .rx_overrun_o);
    sshi_host_model sshi_host_model_inst (.miso_i(miso_w), .spi_clk_o(spi_clk_i),
        .spi_cs_n_o(spi_cs_n_i), .spi_mosi_o(spi_mosi_i), .got_stb_o(got_stb),
        .got_word_o(got_word));

    // Undriven data line wanders so a stale value never looks right
    assign miso_w = spi_miso_oe_o ? spi_miso_o : float_q;
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) float_q <= ~float_q;
    always @(negedge clk_i) rx_ready_i = $random(seed);

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Inbound monitor takes the oldest note per accepted word; also the hang limit
    always @(posedge clk_i) begin
        if (reset_n_i && rx_overrun_o !== 1'b0) chk_bit(rx_overrun_o, 1'b0);
        if (reset_n_i && rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
            if (rx_exp_q.size() == 0) chk_bit(rx_valid_o, 1'b0);
            else chk_word(rx_data_o, rx_exp_q.pop_front());
        end
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            report_and_stop();
        end
    end
    // Outbound monitor skips fill words, which carry no queued data
    always @(posedge got_stb) begin
        if (tx_watch && got_word !== 32'h00000000) begin
            if (tx_exp_q.size() == 0) chk_word(got_word, 32'h00000000);
            else chk_word(got_word, tx_exp_q.pop_front());
        end
    end

    // ------------------------------------------------------------
    // Drivers: queue push, static config, host frame
    // ------------------------------------------------------------
    task automatic push(input logic [31:0] v, input logic m8);
        @(negedge clk_i);
        tx_valid_i = 1'b1;
        tx_data_i  = v;
        ok = 1'b0;
        for (int k = 0; k < 40 && !ok; k++) begin
            @(posedge clk_i);
            ok = (tx_ready_o === 1'b1);
        end
        @(negedge clk_i);
        tx_valid_i = 1'b0;
        if (ok) tx_exp_q.push_back(m8 ? (v & BYTE_MASK) : v);
    endtask
    // Config only moves with select high, then settles before a frame
    task automatic cfg(input logic pol, input logic pha, input logic hf, input logic w32);
        @(negedge clk_i);
        clock_polarity_sel_i = pol;
        clock_phase_sel_i = pha;
        high_freq_sel_i = hf;
        word_32_sel_i = w32;
        repeat (10) @(negedge clk_i);
    endtask
    task automatic frame(input int words, input int bits, input logic pol, input logic hf,
                         input int gap, input logic note);
        logic [31:0] w;
        sshi_host_model_inst.start(pol);
        for (int k = 0; k < words; k++) begin
            w = $random(seed);
            if (note) rx_exp_q.push_back(bits == 8 ? (w & BYTE_MASK) : w);
            sshi_host_model_inst.word(bits, w, hf, gap);
        end
        sshi_host_model_inst.stop(pol);
        repeat (20) @(negedge clk_i);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h5866b081;
        {reset_n_i, tx_valid_i, rx_ready_i, float_q} = 4'h0;
        {clock_polarity_sel_i, clock_phase_sel_i, high_freq_sel_i, word_32_sel_i} = 4'h0;
        ce_i = 1'b1;
        tx_data_i = 32'h00000000;
        {err_count, checks_done, cycles} = {32'h0, 32'h0, 32'h0};
        tx_watch = 1'b1;
        repeat (16) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk_bit(spi_miso_oe_o, 1'b0);
        chk_bit(frame_active_o, 1'b0);
        chk_bit(irq_o, 1'b0);
        // Mode 0, low speed, bytes: queued words raise a level until read
        cfg(1'b0, 1'b0, 1'b0, 1'b0);
        for (n = 0; n < 4; n++) push($random(seed) | 32'h00000001, 1'b1);
        repeat (4) @(negedge clk_i);
        chk_bit(irq_o, 1'b1);
        fork
            frame(8, 8, 1'b0, 1'b0, 0, 1'b1);
            begin
                #400;
                chk_bit(spi_miso_oe_o, 1'b1);
                chk_bit(frame_active_o, 1'b1);
            end
        join
        chk_bit(irq_o, 1'b0);
        // Mode 3, high speed, 32-bit words, host stalling between words
        cfg(1'b1, 1'b1, 1'b1, 1'b1);
        chk_bit(mode_err_o, 1'b0);
        for (n = 0; n < 3; n++) push($random(seed) | 32'h00000001, 1'b0);
        frame(6, 32, 1'b1, 1'b1, 400, 1'b1);
        chk_bit(irq_o, 1'b0);
        // Partial word at release is dropped, next frame starts aligned
        cfg(1'b0, 1'b0, 1'b0, 1'b0);
        frame(1, 5, 1'b0, 1'b0, 0, 1'b0);
        frame(2, 8, 1'b0, 1'b0, 0, 1'b1);
        // Unserved polarity and phase pair: flagged, output floats, words dropped
        cfg(1'b1, 1'b0, 1'b0, 1'b0);
        chk_bit(mode_err_o, 1'b1);
        tx_watch = 1'b0;
        fork
            frame(2, 8, 1'b1, 1'b0, 0, 1'b0);
            begin
                #400;
                chk_bit(spi_miso_oe_o, 1'b0);
            end
        join
        tx_watch = 1'b1;
        // Fill the outbound queue until refused, then drain with a slow host
        cfg(1'b0, 1'b0, 1'b0, 1'b0);
        n = 0;
        ok = 1'b1;
        while (ok) begin
            push($random(seed) | 32'h00000001, 1'b1);
            if (ok) n++;
        end
        chk_word(32'(n), 32'(FIFO_DEPTH + 1));
        frame(40, 8, 1'b0, 1'b0, 200, 1'b1);
        chk_bit(irq_o, 1'b0);
        chk_word(32'(tx_exp_q.size() + rx_exp_q.size()), 32'h00000000);
        report_and_stop();
    end
endmodule
